/* File: verilog/ccl_params.svh */
// Register offsets, field positions, reset values and timing counts of the comparator control
`ifndef CCL_PARAMS_SVH
`define CCL_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CCL_ADDR_W            8
`define CCL_OFS_CONTROL_A     8'h00
`define CCL_OFS_CONTROL_B     8'h04
`define CCL_OFS_MIRROR        8'h08
`define CCL_OFS_PIN           8'h0C

// ----------------------------------------------------------------
// Field positions of cmp_control_a
// ----------------------------------------------------------------
`define CCL_A_ENABLE          7
`define CCL_A_RESULT          6
`define CCL_A_PIN_OE          5
`define CCL_A_INVERT          4
`define CCL_A_SPEED           2
`define CCL_A_HYST            1
`define CCL_A_SYNC            0

// ----------------------------------------------------------------
// Field positions of the mirror and pin registers
// ----------------------------------------------------------------
`define CCL_M_RESULT          0
`define CCL_P_DIRECTION       0
`define CCL_P_LATCH           1
`define CCL_P_LEVEL           2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCL_RST_SPEED         1'b1
`define CCL_RST_DIRECTION     1'b1
`define CCL_RST_CONTROL_B     8'h00

// ----------------------------------------------------------------
// Timing: instruction cycle is four clock periods
// ----------------------------------------------------------------
`define CCL_CLK_PERIOD_NS     50
`define CCL_INSTR_CYCLE_NS    200
`define CCL_INSTR_CLKS        (`CCL_INSTR_CYCLE_NS / `CCL_CLK_PERIOD_NS)

`endif

/* File: verilog/ccl_pkg.sv */
// Types shared by the comparator control block
`default_nettype none
package ccl_pkg;

    // Control fields held from cmp_control_a
    typedef struct packed {
        logic enable;
        logic pin_oe;
        logic invert;
        logic speed;
        logic hyst;
        logic sync;
    } ccl_ctrl_s;

    // Pin fields held from the pin register
    typedef struct packed {
        logic direction;
        logic latch;
    } ccl_pin_s;

    // Captured bus address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ccl_bus_s;

    // Bus slave states
    typedef enum logic [0:0] {
        CCL_BUS_IDLE,
        CCL_BUS_READ
    } ccl_bus_state_e;

endpackage
`default_nettype wire

/* File: verilog/ccl_cycle_div.sv */
// Divider making the one-cycle instruction-cycle enable pulse
`timescale 1ns/10ps
`default_nettype none
`include "ccl_params.svh"

module ccl_cycle_div
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    output var  logic instr_tick
);
    localparam logic [1:0] LAST = 2'(`CCL_INSTR_CLKS - 1);

    logic [1:0] count;
    logic [1:0] next_count;
    logic       next_instr_tick;

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------

    // Wrap at the last count and pulse there
    always_comb
    begin
        next_instr_tick = (count == LAST);
        next_count      = (count == LAST) ? 2'h0 : count + 2'h1;
    end

    // Register the counter and pulse
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count      <= 2'h0;
            instr_tick <= 1'b0;
        end
        else
        begin
            count      <= next_count;
            instr_tick <= next_instr_tick;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/ccl_pin_mux.sv */
// Pin driver choosing between the comparator result and the port data latch
`timescale 1ns/10ps
`default_nettype none

module ccl_pin_mux
(
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire ccl_pkg::ccl_ctrl_s ctrl,
    input  wire ccl_pkg::ccl_pin_s  pin_cfg,
    input  wire logic             live_result,
    input  wire logic             held_result,
    output var  logic             pin_out,
    output var  logic             pin_oe
);
    import ccl_pkg::*;

    logic next_pin_out;
    logic next_pin_oe;
    logic pin_result;

    // ----------------------------------------------------------------
    // Pin selection
    // ----------------------------------------------------------------

    // Sync option picks the held result, otherwise the live one
    always_comb
    begin
        pin_result   = ctrl.sync ? held_result : live_result;
        next_pin_oe  = ~pin_cfg.direction;
        // Override of the latch ignores the enable bit; a disabled unit gives 0, with sync only from the next instruction cycle
        next_pin_out = ctrl.pin_oe ? pin_result : pin_cfg.latch;
    end

    // Register the pin outputs
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end
        else
        begin
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/ccl_top.sv */
// Comparator control block: AHB-Lite registers, polarity, result latch and pin override
`timescale 1ns/10ps
`default_nettype none
`include "ccl_params.svh"

module ccl_top
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    input  wire logic        raw_compare,
    output var  logic        cmp_power_on,
    output var  logic        cmp_speed_power_select,
    output var  logic        cmp_hyst_on,
    output var  logic [7:0]  cmp_control_b_out,
    input  wire logic        pin_in,
    output var  logic        pin_out,
    output var  logic        pin_oe
);
    import ccl_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ccl_ctrl_s      ctrl;
    ccl_ctrl_s      next_ctrl;
    ccl_pin_s       pin_cfg;
    ccl_pin_s       next_pin_cfg;
    logic [7:0]     control_b;
    logic [7:0]     next_control_b;
    logic           held_result;
    logic           next_held_result;
    logic           pin_level;
    logic           next_pin_level;
    ccl_bus_s       bus_ph;
    ccl_bus_s       next_bus_ph;
    ccl_bus_state_e bus_state;
    ccl_bus_state_e next_bus_state;
    logic [31:0]    next_hrdata;
    logic           next_hreadyout;
    logic           next_power_on;
    logic           next_speed_out;
    logic           next_hyst_out;
    logic [7:0]     next_control_b_out;
    logic           live_result;
    logic           instr_tick;
    logic           accept;
    logic           wr_commit;

    // Byte address of a bus request, word aligned
    function automatic logic [7:0] word_addr(input logic [31:0] a);
        word_addr = {a[7:2], 2'b00};
    endfunction

    // Read value of a register, zero for unmapped offsets
    function automatic logic [31:0] read_value(
        input logic [7:0] a,
        input ccl_ctrl_s  c,
        input ccl_pin_s   p,
        input logic [7:0] b,
        input logic       r,
        input logic       lvl
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            `CCL_OFS_CONTROL_A:
            begin
                v[`CCL_A_ENABLE] = c.enable;
                v[`CCL_A_RESULT] = r;
                v[`CCL_A_PIN_OE] = c.pin_oe;
                v[`CCL_A_INVERT] = c.invert;
                v[`CCL_A_SPEED]  = c.speed;
                v[`CCL_A_HYST]   = c.hyst;
                v[`CCL_A_SYNC]   = c.sync;
            end
            `CCL_OFS_CONTROL_B:
            begin
                v[7:0] = b;
            end
            `CCL_OFS_MIRROR:
            begin
                v[`CCL_M_RESULT] = r;
            end
            `CCL_OFS_PIN:
            begin
                v[`CCL_P_DIRECTION] = p.direction;
                v[`CCL_P_LATCH]     = p.latch;
                v[`CCL_P_LEVEL]     = lvl;
            end
            default:
            begin
                v = 32'h0000_0000;
            end
        endcase
        read_value = v;
    endfunction

    // ----------------------------------------------------------------
    // Instruction-cycle enable
    // ----------------------------------------------------------------
    ccl_cycle_div i_ccl_cycle_div
    (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .instr_tick (instr_tick)
    );

    // ----------------------------------------------------------------
    // Result path
    // ----------------------------------------------------------------

    // Polarity applied to the raw input; a disabled unit gives 0
    assign live_result = ctrl.enable & (raw_compare ^ ctrl.invert);

    // Hold the result on each instruction cycle
    always_comb
    begin
        next_held_result = instr_tick ? live_result : held_result;
        next_pin_level   = pin_in;
    end

    // Register the held result and the pin level
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            held_result <= 1'b0;
            pin_level   <= 1'b0;
        end
        else
        begin
            held_result <= next_held_result;
            pin_level   <= next_pin_level;
        end
    end

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    assign accept    = hsel & htrans[1] & hready;
    assign wr_commit = bus_ph.valid & bus_ph.write;

    // Writes finish with no wait; reads take one wait state
    always_comb
    begin
        next_bus_ph       = bus_ph;
        next_bus_state    = bus_state;
        next_hreadyout    = hreadyout;
        next_hrdata       = hrdata;
        if (hready)
        begin
            next_bus_ph.valid = accept;
            next_bus_ph.write = hwrite;
            next_bus_ph.addr  = word_addr(haddr);
        end
        unique case (bus_state)
            CCL_BUS_IDLE:
            begin
                if (accept && !hwrite)
                begin
                    next_bus_state = CCL_BUS_READ;
                    next_hreadyout = 1'b0;
                end
                else
                begin
                    next_hreadyout = 1'b1;
                end
            end
            CCL_BUS_READ:
            begin
                next_hrdata    = read_value(bus_ph.addr, ctrl, pin_cfg, control_b,
                                            held_result, pin_level);
                next_hreadyout = 1'b1;
                next_bus_state = CCL_BUS_IDLE;
                next_bus_ph.valid = 1'b0;
            end
        endcase
    end

    // Register the bus state
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bus_ph    <= '0;
            bus_state <= CCL_BUS_IDLE;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end
        else
        begin
            bus_ph    <= next_bus_ph;
            bus_state <= next_bus_state;
            hreadyout <= next_hreadyout;
            hrdata    <= next_hrdata;
            hresp     <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------

    // Write data lands in the data phase; unmapped writes are dropped
    always_comb
    begin
        next_ctrl      = ctrl;
        next_pin_cfg   = pin_cfg;
        next_control_b = control_b;
        if (wr_commit && bus_ph.addr == `CCL_OFS_CONTROL_A)
        begin
            next_ctrl.enable = hwdata[`CCL_A_ENABLE];
            next_ctrl.pin_oe = hwdata[`CCL_A_PIN_OE];
            next_ctrl.invert = hwdata[`CCL_A_INVERT];
            next_ctrl.speed  = hwdata[`CCL_A_SPEED];
            next_ctrl.hyst   = hwdata[`CCL_A_HYST];
            next_ctrl.sync   = hwdata[`CCL_A_SYNC];
        end
        if (wr_commit && bus_ph.addr == `CCL_OFS_CONTROL_B)
        begin
            next_control_b = hwdata[7:0];
        end
        if (wr_commit && bus_ph.addr == `CCL_OFS_PIN)
        begin
            next_pin_cfg.direction = hwdata[`CCL_P_DIRECTION];
            next_pin_cfg.latch     = hwdata[`CCL_P_LATCH];
        end
    end

    // Register the control state
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl           <= '0;
            ctrl.speed     <= `CCL_RST_SPEED;
            pin_cfg.direction <= `CCL_RST_DIRECTION;
            pin_cfg.latch  <= 1'b0;
            control_b      <= `CCL_RST_CONTROL_B;
        end
        else
        begin
            ctrl           <= next_ctrl;
            pin_cfg        <= next_pin_cfg;
            control_b      <= next_control_b;
        end
    end

    // ----------------------------------------------------------------
    // Analog front end controls
    // ----------------------------------------------------------------

    // Power, speed and hysteresis go off while the unit is disabled
    always_comb
    begin
        next_power_on      = ctrl.enable;
        next_speed_out     = ctrl.enable & ctrl.speed;
        next_hyst_out      = ctrl.enable & ctrl.hyst;
        next_control_b_out = control_b;
    end

    // Register the front end controls
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cmp_power_on           <= 1'b0;
            cmp_speed_power_select <= 1'b0;
            cmp_hyst_on            <= 1'b0;
            cmp_control_b_out      <= `CCL_RST_CONTROL_B;
        end
        else
        begin
            cmp_power_on           <= next_power_on;
            cmp_speed_power_select <= next_speed_out;
            cmp_hyst_on            <= next_hyst_out;
            cmp_control_b_out      <= next_control_b_out;
        end
    end

    // ----------------------------------------------------------------
    // Pin output
    // ----------------------------------------------------------------
    ccl_pin_mux i_ccl_pin_mux
    (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .ctrl        (ctrl),
        .pin_cfg     (pin_cfg),
        .live_result (live_result),
        .held_result (held_result),
        .pin_out     (pin_out),
        .pin_oe      (pin_oe)
    );
endmodule
`default_nettype wire

/* File: verification/ccl_front_end_model.sv */
// Behavioural model of the analog comparator front end and the I/O pin
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Front end and pin model
// ----------------------------------------------------------------
module ccl_front_end_model
#(
    parameter logic PULL_LEVEL = 1'b1
)
(
    input  wire logic [11:0] positive_input_voltage,
    input  wire logic [11:0] negative_input_voltage,
    input  wire logic        pin_out,
    input  wire logic        pin_oe,
    output var  logic        raw_compare,
    output var  logic        pin_in
);
    // Raw comparison, high when the positive input is the higher one
    always_comb raw_compare = (positive_input_voltage > negative_input_voltage);
    // Released pin falls to the pull level, never keeps the last driven value
    always_comb pin_in = pin_oe ? pin_out : PULL_LEVEL;
endmodule

`default_nettype wire

/* File: verification/ccl_top_checker.sv */
// Concurrent checks on the ports of the comparator control block
`timescale 1ns/10ps
`default_nettype none
`include "ccl_params.svh"

module ccl_top_checker
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic        hreadyout,
    input  wire logic        hresp,
    input  wire logic        raw_compare,
    input  wire logic        cmp_power_on,
    input  wire logic        cmp_speed_power_select,
    input  wire logic        pin_out,
    input  wire logic        pin_oe
);
    logic       dp_wr;
    logic [7:0] dp_addr;
    logic [7:0] sh_a;
    logic [1:0] sh_p;

    // ----------------------------------------------------------------
    // Shadow of the written control and pin registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dp_wr   <= 1'b0;
            dp_addr <= 8'h00;
            sh_a    <= 8'h04;
            sh_p    <= 2'b01;
        end
        else if (hready)
        begin
            dp_wr   <= hsel & htrans[1] & hwrite;
            dp_addr <= haddr[7:0];
            if (dp_wr && dp_addr == `CCL_OFS_CONTROL_A)
                sh_a <= hwdata[7:0];
            if (dp_wr && dp_addr == `CCL_OFS_PIN)
                sh_p <= hwdata[1:0];
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_rd_taken;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_wr_taken;
        hsel && htrans[1] && hready && hwrite;
    endsequence
    sequence s_read_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    property p_power;
        cmp_power_on == $past(sh_a[7]);
    endproperty
    property p_speed;
        cmp_speed_power_select == $past(sh_a[7] & sh_a[2]);
    endproperty
    property p_pin_dir;
        pin_oe == $past(~sh_p[0]);
    endproperty
    property p_pin_live;
        $past(sh_a[5] & ~sh_a[0]) |-> pin_out == $past(sh_a[7] & (raw_compare ^ sh_a[4]));
    endproperty
    property p_pin_latch;
        $past(~sh_a[5]) |-> pin_out == $past(sh_p[1]);
    endproperty
    property p_okay;
        hresp == 1'b0;
    endproperty
    property p_read_wait;
        s_rd_taken |=> s_read_wait;
    endproperty
    property p_write_nowait;
        s_wr_taken |=> hreadyout;
    endproperty

    a_power: assert property (p_power) else $error("power output differs from enable bit");
    a_speed: assert property (p_speed) else $error("speed output differs from select bit");
    a_pin_dir: assert property (p_pin_dir) else $error("pin drive differs from direction");
    a_pin_live: assert property (p_pin_live) else $error("pin does not follow the result");
    a_pin_latch: assert property (p_pin_latch) else $error("pin does not follow the latch");
    a_okay: assert property (p_okay) else $error("bus response not okay");
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
    a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
endmodule

bind ccl_top ccl_top_checker i_ccl_top_checker (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .raw_compare(raw_compare),
    .cmp_power_on(cmp_power_on), .cmp_speed_power_select(cmp_speed_power_select),
    .pin_out(pin_out), .pin_oe(pin_oe));

`default_nettype wire

/* File: verification/tb_ccl_top.sv */
// Self-checking testbench of the comparator control block
`timescale 1ns/10ps
`default_nettype none
`include "ccl_params.svh"

module tb_ccl_top;
    logic ref_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [11:0] pos_v = 12'h100, neg_v = 12'h200;
    logic hreadyout, hresp, raw_compare, cmp_power_on, cmp_speed_power_select, pin_in;
    logic pin_out, pin_oe, cmp_hyst_on;
    logic [7:0] cmp_control_b_out;
    int miscompares = 0, n_compared = 0, cyc = 0;

    ccl_top i_ccl_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .raw_compare(raw_compare),
        .cmp_power_on(cmp_power_on), .cmp_speed_power_select(cmp_speed_power_select),
        .cmp_hyst_on(cmp_hyst_on), .cmp_control_b_out(cmp_control_b_out), .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe(pin_oe));
    ccl_front_end_model i_ccl_front_end_model (.positive_input_voltage(pos_v),
        .negative_input_voltage(neg_v), .pin_out(pin_out), .pin_oe(pin_oe),
        .raw_compare(raw_compare), .pin_in(pin_in));

    // ----------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------------------------------
    initial forever #25 ref_clk = ~ref_clk;

    // Cut a hang short
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // One single transfer; read data taken at the closing edge
    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, q);
    endtask

    task automatic rd_check(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus_xfer(1'b0, a, 32'h0, q);
        check(nm, exp, q);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values();
        check("power_rst", 32'h0, {31'h0, cmp_power_on});
        rd_check("ctl_a_rst", `CCL_OFS_CONTROL_A, 32'h00000004);
        rd_check("mirror_rst", `CCL_OFS_MIRROR, 32'h0);
        rd_check("pin_rst", `CCL_OFS_PIN, 32'h00000005);
        wr(8'h10, 32'hFFFFFFFF);
        rd_check("unmapped", 8'h10, 32'h0);
    endtask

    task automatic t_speed();
        wr(`CCL_OFS_CONTROL_A, 32'h00000084);
        idle(2);
        check("power_on", 32'h1, {31'h0, cmp_power_on});
        check("speed_norm", 32'h1, {31'h0, cmp_speed_power_select});
        wr(`CCL_OFS_CONTROL_A, 32'h00000080);
        idle(2);
        check("speed_low", 32'h0, {31'h0, cmp_speed_power_select});
    endtask

    // Every polarity against both input orders
    task automatic t_polarity();
        logic inv;
        logic up;
        logic res;
        for (int k = 0; k < 4; k++)
        begin
            inv = k[0];
            up = k[1];
            res = up ^ inv;
            pos_v <= up ? 12'h300 : 12'h100;
            wr(`CCL_OFS_CONTROL_A, {24'h0, 1'b1, 2'b00, inv, 4'h0});
            idle(12);
            rd_check("ctl_a_res", `CCL_OFS_CONTROL_A, {24'h0, 1'b1, res, 1'b0, inv, 4'h0});
            rd_check("mirror_res", `CCL_OFS_MIRROR, {31'h0, res});
        end
    endtask

    task automatic t_disabled();
        pos_v <= 12'h300;
        wr(`CCL_OFS_CONTROL_A, 32'h0);
        idle(12);
        check("power_off", 32'h0, {31'h0, cmp_power_on});
        rd_check("mirror_off", `CCL_OFS_MIRROR, 32'h0);
    endtask

    task automatic t_pin();
        wr(`CCL_OFS_PIN, 32'h00000002);
        wr(`CCL_OFS_CONTROL_A, 32'h00000080);
        idle(3);
        check("pin_drive", 32'h1, {31'h0, pin_oe});
        check("pin_latch", 32'h1, {31'h0, pin_out});
        wr(`CCL_OFS_CONTROL_A, 32'h000000A0);
        pos_v <= 12'h100;
        idle(2);
        check("pin_live", 32'h0, {31'h0, pin_out});
        pos_v <= 12'h300;
        idle(2);
        check("pin_follow", 32'h1, {31'h0, pin_out});
        wr(`CCL_OFS_CONTROL_A, 32'h000000B0);
        idle(3);
        check("pin_inv", 32'h0, {31'h0, pin_out});
        wr(`CCL_OFS_CONTROL_A, 32'h00000020);
        idle(3);
        check("pin_ovr_off", 32'h0, {31'h0, pin_out});
        check("pin_drive_off", 32'h1, {31'h0, pin_oe});
        wr(`CCL_OFS_PIN, 32'h00000003);
        idle(3);
        check("pin_release", 32'h0, {31'h0, pin_oe});
        rd_check("pin_reg", `CCL_OFS_PIN, 32'h00000007);
    endtask

    // Hysteresis and second register outputs, sync pin path, reset in mid-run
    task automatic t_misc();
        wr(`CCL_OFS_CONTROL_B, 32'h000000A5);
        wr(`CCL_OFS_CONTROL_A, 32'h00000082);
        idle(2);
        check("hyst_on", 32'h1, {31'h0, cmp_hyst_on});
        check("ctl_b_out", 32'hA5, {24'h0, cmp_control_b_out});
        rd_check("ctl_b", `CCL_OFS_CONTROL_B, 32'h000000A5);
        wr(`CCL_OFS_PIN, 32'h00000000);
        pos_v <= 12'h300;
        wr(`CCL_OFS_CONTROL_A, 32'h000000A1);
        idle(12);
        check("pin_sync", 32'h1, {31'h0, pin_out});
        rd_check("ctl_a_sync", `CCL_OFS_CONTROL_A, 32'h000000E1);
        sys_rst <= 1'b1;
        idle(2);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check("pin_oe_rst2", 32'h0, {31'h0, pin_oe});
        check("power_rst2", 32'h0, {31'h0, cmp_power_on});
        rd_check("ctl_a_rst2", `CCL_OFS_CONTROL_A, 32'h00000004);
        rd_check("ctl_b_rst2", `CCL_OFS_CONTROL_B, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_reset_values();
        t_speed();
        t_polarity();
        t_disabled();
        t_pin();
        t_misc();
        idle(4);
        conclude();
    end
endmodule

`default_nettype wire
